// ==== rtl/cepv_params.svh ====
// Constants for the event priority and vectoring block
`ifndef CEPV_PARAMS_SVH
`define CEPV_PARAMS_SVH

// Sizes
`define CEPV_NUM_EVT 28
`define CEPV_IDX_W 5
`define CEPV_ADDR_W 32
`define CEPV_AUTOVEC_W 14
`define CEPV_NUM_IRQ 4
`define CEPV_STACK_DEPTH 32
`define CEPV_SP_W 6

// Priority and stack pointer values
`define CEPV_PRIO_IDLE 5'h1f
`define CEPV_PRIO_STEP 5'h01
`define CEPV_SP_STEP 6'h01
`define CEPV_SP_EMPTY 6'h00

// Event index (priority minus one)
`define CEPV_IDX_RESET 5'h00
`define CEPV_IDX_DBG_STOP 5'h01
`define CEPV_IDX_UNRECOV 5'h02
`define CEPV_IDX_MULTI_HIT 5'h03
`define CEPV_IDX_BUSERR_DATA 5'h04
`define CEPV_IDX_BUSERR_INSTR 5'h05
`define CEPV_IDX_NMI 5'h06
`define CEPV_IDX_IRQ3 5'h07
`define CEPV_IDX_IRQ2 5'h08
`define CEPV_IDX_IRQ1 5'h09
`define CEPV_IDX_IRQ0 5'h0a
`define CEPV_IDX_IADDR 5'h0b
`define CEPV_IDX_IPROT_MISS 5'h0c
`define CEPV_IDX_IPROT_VIOL 5'h0d
`define CEPV_IDX_BKPT 5'h0e
`define CEPV_IDX_ILLEGAL 5'h0f
`define CEPV_IDX_UNIMPL 5'h10
`define CEPV_IDX_PRIV 5'h11
`define CEPV_IDX_FPU 5'h12
`define CEPV_IDX_COP_ABSENT 5'h13
`define CEPV_IDX_SVC 5'h14
`define CEPV_IDX_DADDR_RD 5'h15
`define CEPV_IDX_DADDR_WR 5'h16
`define CEPV_IDX_DPROT_MISS_RD 5'h17
`define CEPV_IDX_DPROT_MISS_WR 5'h18
`define CEPV_IDX_DPROT_VIOL_RD 5'h19
`define CEPV_IDX_DPROT_VIOL_WR 5'h1a
`define CEPV_IDX_DMODIFIED 5'h1b

// Fixed addresses and handler offsets from the event vector base
`define CEPV_RESET_ADDR 32'h8000_0000
`define CEPV_OFF_UNRECOV 32'h0000_0000
`define CEPV_OFF_MULTI_HIT 32'h0000_0004
`define CEPV_OFF_BUSERR_DATA 32'h0000_0008
`define CEPV_OFF_BUSERR_INSTR 32'h0000_000c
`define CEPV_OFF_NMI 32'h0000_0010
`define CEPV_OFF_IADDR 32'h0000_0014
`define CEPV_OFF_IPROT_VIOL 32'h0000_0018
`define CEPV_OFF_BKPT 32'h0000_001c
`define CEPV_OFF_ILLEGAL 32'h0000_0020
`define CEPV_OFF_UNIMPL 32'h0000_0024
`define CEPV_OFF_PRIV 32'h0000_0028
`define CEPV_OFF_FPU 32'h0000_002c
`define CEPV_OFF_COP_ABSENT 32'h0000_0030
`define CEPV_OFF_DADDR_RD 32'h0000_0034
`define CEPV_OFF_DADDR_WR 32'h0000_0038
`define CEPV_OFF_DPROT_VIOL_RD 32'h0000_003c
`define CEPV_OFF_DPROT_VIOL_WR 32'h0000_0040
`define CEPV_OFF_DMODIFIED 32'h0000_0044
`define CEPV_OFF_IPROT_MISS 32'h0000_0050
`define CEPV_OFF_DPROT_MISS_RD 32'h0000_0060
`define CEPV_OFF_DPROT_MISS_WR 32'h0000_0070
`define CEPV_OFF_SVC 32'h0000_0100
`define CEPV_SVC_RET_INC 32'h0000_0002
`define CEPV_ZERO_ADDR 32'h0000_0000
`define CEPV_AUTOVEC_PAD 18'h00000

`endif

// ==== rtl/cepv_pkg.sv ====
// Types for the event priority and vectoring block
`include "cepv_params.svh"

package cepv_pkg;

  // Where the stored return address comes from
  typedef enum logic [1:0] {
    CEPV_RET_NONE,
    CEPV_RET_OFFENDING,
    CEPV_RET_FIRST_NC,
    CEPV_RET_SVC
  } cepv_ret_kind_t;

  // How the handler address is formed
  typedef enum logic [1:0] {
    CEPV_VEC_FIXED,
    CEPV_VEC_DEBUG,
    CEPV_VEC_AUTO,
    CEPV_VEC_BASE
  } cepv_vec_kind_t;

  typedef logic [`CEPV_NUM_EVT-1:0] cepv_evt_vec_t;
  typedef logic [`CEPV_IDX_W-1:0] cepv_idx_t;
  typedef logic [`CEPV_ADDR_W-1:0] cepv_addr_t;

endpackage

// ==== rtl/cepv_prio_enc.sv ====
// Lowest-index-wins priority encoder over pending events
`timescale 1ns/100ps
`include "cepv_params.svh"

module cepv_prio_enc (
  // Pending events, bit 0 highest priority
  input wire cepv_pkg::cepv_evt_vec_t req,
  // Winner
  output logic found,
  output cepv_pkg::cepv_idx_t idx
);
  import cepv_pkg::*;

  // Scan downward so the lowest set index is kept last
  always_comb begin
    found = 1'b0;
    idx = `CEPV_IDX_RESET;
    for (int i = `CEPV_NUM_EVT - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 5'(i);
      end
    end
  end

endmodule

// ==== rtl/cepv_top.sv ====
// Event prioritisation and handler vectoring for the CPU
// How it works
// - Debug stop: priority 2, debug-supplied handler address
// - Unrecoverable: priority 3, offset 0x00, offending PC
// - Multiple lookup hit: priority 4, offset 0x04
// - Bus errors: data 0x08/5, instruction 0x0C/6
// - NMI: priority 7, offset 0x10, first non-completed
// - IRQ levels 3..0 take priorities 8..11, autovectored
// - Instruction address fault: priority 12, offset 0x14
// - Instr lookup miss 0x50/13, violation 0x18/14
// - Breakpoint: priority 15, offset 0x1C
// - Illegal 0x20, unimplemented 0x24, privilege 0x28
// - Floating-point and data-modified slots never raised
// - Absent coprocessor: priority 20, offset 0x30
// - Supervisor call: priority 21, 0x100, PC plus 2
// - Data address faults: read 0x34, write 0x38
// - Data lookup misses: read 0x60, write 0x70
// - Data violations: read 0x3C, write 0x40
// - Reset first, priority 1, address 0x8000_0000
// - Handler address is base OR offset
// - Autovector offset 14 bits relative to base
// - Higher class preempts handling of lower class
`timescale 1ns/100ps
`include "cepv_params.svh"

module cepv_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // External pins, asynchronous
  input wire logic nmi_pin,
  input wire logic [`CEPV_NUM_IRQ-1:0] irq_pin,
  // Interrupt controller
  input wire logic [`CEPV_AUTOVEC_W-1:0] irq_autovector,
  output logic [`CEPV_NUM_IRQ-1:0] irq_ack_r,
  // Debug system
  input wire logic dbg_stop_req,
  input wire logic dbg_breakpoint,
  input wire cepv_pkg::cepv_addr_t dbg_handler_addr,
  // Protection unit
  input wire logic prot_multi_hit,
  input wire logic instr_protection_lookup_miss,
  input wire logic instr_protection_lookup_viol,
  input wire logic data_protection_lookup_miss_rd,
  input wire logic data_protection_lookup_miss_wr,
  input wire logic data_protection_lookup_viol_rd,
  input wire logic data_protection_lookup_viol_wr,
  // Bus interfaces
  input wire logic bus_err_data,
  input wire logic bus_err_instr,
  // Pipeline fault pulses
  input wire logic unrecov_fault,
  input wire logic instr_addr_fault,
  input wire logic illegal_opcode,
  input wire logic unimpl_instr,
  input wire logic priv_violation,
  input wire logic cop_absent,
  input wire logic supervisor_call,
  input wire logic data_addr_fault_rd,
  input wire logic data_addr_fault_wr,
  // Pipeline context
  input wire cepv_pkg::cepv_addr_t event_vector_base,
  input wire cepv_pkg::cepv_addr_t pc_offending,
  input wire cepv_pkg::cepv_addr_t pc_first_nc,
  input wire logic evt_ready,
  input wire logic evt_done,
  // Event handed to the pipeline
  output logic evt_take_r,
  output cepv_pkg::cepv_addr_t evt_handler_addr_r,
  output cepv_pkg::cepv_addr_t evt_return_addr_r,
  output logic evt_return_valid_r,
  output cepv_pkg::cepv_idx_t evt_prio_r,
  output cepv_pkg::cepv_idx_t cur_prio_r
);
  import cepv_pkg::*;

  // Fixed handler offset of each event
  function automatic cepv_addr_t evt_offset(input cepv_idx_t i);
    case (i)
      `CEPV_IDX_UNRECOV: evt_offset = `CEPV_OFF_UNRECOV;
      `CEPV_IDX_MULTI_HIT: evt_offset = `CEPV_OFF_MULTI_HIT;
      `CEPV_IDX_BUSERR_DATA: evt_offset = `CEPV_OFF_BUSERR_DATA;
      `CEPV_IDX_BUSERR_INSTR: evt_offset = `CEPV_OFF_BUSERR_INSTR;
      `CEPV_IDX_NMI: evt_offset = `CEPV_OFF_NMI;
      `CEPV_IDX_IADDR: evt_offset = `CEPV_OFF_IADDR;
      `CEPV_IDX_IPROT_MISS: evt_offset = `CEPV_OFF_IPROT_MISS;
      `CEPV_IDX_IPROT_VIOL: evt_offset = `CEPV_OFF_IPROT_VIOL;
      `CEPV_IDX_BKPT: evt_offset = `CEPV_OFF_BKPT;
      `CEPV_IDX_ILLEGAL: evt_offset = `CEPV_OFF_ILLEGAL;
      `CEPV_IDX_UNIMPL: evt_offset = `CEPV_OFF_UNIMPL;
      `CEPV_IDX_PRIV: evt_offset = `CEPV_OFF_PRIV;
      `CEPV_IDX_FPU: evt_offset = `CEPV_OFF_FPU;
      `CEPV_IDX_COP_ABSENT: evt_offset = `CEPV_OFF_COP_ABSENT;
      `CEPV_IDX_SVC: evt_offset = `CEPV_OFF_SVC;
      `CEPV_IDX_DADDR_RD: evt_offset = `CEPV_OFF_DADDR_RD;
      `CEPV_IDX_DADDR_WR: evt_offset = `CEPV_OFF_DADDR_WR;
      `CEPV_IDX_DPROT_MISS_RD: evt_offset = `CEPV_OFF_DPROT_MISS_RD;
      `CEPV_IDX_DPROT_MISS_WR: evt_offset = `CEPV_OFF_DPROT_MISS_WR;
      `CEPV_IDX_DPROT_VIOL_RD: evt_offset = `CEPV_OFF_DPROT_VIOL_RD;
      `CEPV_IDX_DPROT_VIOL_WR: evt_offset = `CEPV_OFF_DPROT_VIOL_WR;
      `CEPV_IDX_DMODIFIED: evt_offset = `CEPV_OFF_DMODIFIED;
      default: evt_offset = `CEPV_ZERO_ADDR;
    endcase
  endfunction

  // Source of the stored return address
  function automatic cepv_ret_kind_t evt_ret_kind(input cepv_idx_t i);
    case (i)
      `CEPV_IDX_DBG_STOP, `CEPV_IDX_BUSERR_DATA, `CEPV_IDX_BUSERR_INSTR, `CEPV_IDX_NMI,
      `CEPV_IDX_IRQ3, `CEPV_IDX_IRQ2, `CEPV_IDX_IRQ1, `CEPV_IDX_IRQ0,
      `CEPV_IDX_BKPT: evt_ret_kind = CEPV_RET_FIRST_NC;
      `CEPV_IDX_UNRECOV, `CEPV_IDX_IADDR, `CEPV_IDX_IPROT_VIOL, `CEPV_IDX_ILLEGAL,
      `CEPV_IDX_UNIMPL, `CEPV_IDX_PRIV, `CEPV_IDX_COP_ABSENT, `CEPV_IDX_DADDR_RD,
      `CEPV_IDX_DADDR_WR, `CEPV_IDX_DPROT_VIOL_RD,
      `CEPV_IDX_DPROT_VIOL_WR: evt_ret_kind = CEPV_RET_OFFENDING;
      `CEPV_IDX_SVC: evt_ret_kind = CEPV_RET_SVC;
      default: evt_ret_kind = CEPV_RET_NONE;
    endcase
  endfunction

  // How the handler address of each event is formed
  function automatic cepv_vec_kind_t evt_vec_kind(input cepv_idx_t i);
    case (i)
      `CEPV_IDX_RESET: evt_vec_kind = CEPV_VEC_FIXED;
      `CEPV_IDX_DBG_STOP: evt_vec_kind = CEPV_VEC_DEBUG;
      `CEPV_IDX_IRQ3, `CEPV_IDX_IRQ2, `CEPV_IDX_IRQ1,
      `CEPV_IDX_IRQ0: evt_vec_kind = CEPV_VEC_AUTO;
      default: evt_vec_kind = CEPV_VEC_BASE;
    endcase
  endfunction

  // Handler target is the base with the offset ORed in, never added
  function automatic cepv_addr_t form_target(input cepv_addr_t base, input cepv_addr_t off);
    form_target = base | off;
  endfunction

  // Pin synchronisers and NMI edge detect
  logic nmi_s1_r, nmi_s2_r, nmi_s3_r;
  logic [`CEPV_NUM_IRQ-1:0] irq_s1_r, irq_s2_r;
  logic nmi_s1_nxt, nmi_s2_nxt, nmi_s3_nxt;
  logic [`CEPV_NUM_IRQ-1:0] irq_s1_nxt, irq_s2_nxt;

  always_comb begin
    nmi_s1_nxt = nmi_pin;
    nmi_s2_nxt = nmi_s1_r;
    nmi_s3_nxt = nmi_s2_r;
    irq_s1_nxt = irq_pin;
    irq_s2_nxt = irq_s1_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
      irq_s1_r <= '0;
      irq_s2_r <= '0;
    end else begin
      nmi_s1_r <= nmi_s1_nxt;
      nmi_s2_r <= nmi_s2_nxt;
      nmi_s3_r <= nmi_s3_nxt;
      irq_s1_r <= irq_s1_nxt;
      irq_s2_r <= irq_s2_nxt;
    end
  end

  // Event pulses gathered by priority index
  cepv_evt_vec_t evt_set;
  cepv_evt_vec_t irq_level_vec;

  always_comb begin
    evt_set = '0;
    evt_set[`CEPV_IDX_DBG_STOP] = dbg_stop_req;
    evt_set[`CEPV_IDX_UNRECOV] = unrecov_fault;
    evt_set[`CEPV_IDX_MULTI_HIT] = prot_multi_hit;
    evt_set[`CEPV_IDX_BUSERR_DATA] = bus_err_data;
    evt_set[`CEPV_IDX_BUSERR_INSTR] = bus_err_instr;
    evt_set[`CEPV_IDX_NMI] = nmi_s2_r & ~nmi_s3_r;
    evt_set[`CEPV_IDX_IADDR] = instr_addr_fault;
    evt_set[`CEPV_IDX_IPROT_MISS] = instr_protection_lookup_miss;
    evt_set[`CEPV_IDX_IPROT_VIOL] = instr_protection_lookup_viol;
    evt_set[`CEPV_IDX_BKPT] = dbg_breakpoint;
    evt_set[`CEPV_IDX_ILLEGAL] = illegal_opcode;
    evt_set[`CEPV_IDX_UNIMPL] = unimpl_instr;
    evt_set[`CEPV_IDX_PRIV] = priv_violation;
    evt_set[`CEPV_IDX_FPU] = 1'b0;
    evt_set[`CEPV_IDX_COP_ABSENT] = cop_absent;
    evt_set[`CEPV_IDX_SVC] = supervisor_call;
    evt_set[`CEPV_IDX_DADDR_RD] = data_addr_fault_rd;
    evt_set[`CEPV_IDX_DADDR_WR] = data_addr_fault_wr;
    evt_set[`CEPV_IDX_DPROT_MISS_RD] = data_protection_lookup_miss_rd;
    evt_set[`CEPV_IDX_DPROT_MISS_WR] = data_protection_lookup_miss_wr;
    evt_set[`CEPV_IDX_DPROT_VIOL_RD] = data_protection_lookup_viol_rd;
    evt_set[`CEPV_IDX_DPROT_VIOL_WR] = data_protection_lookup_viol_wr;
    evt_set[`CEPV_IDX_DMODIFIED] = 1'b0;
    // Interrupt levels are not latched; the controller holds them
    irq_level_vec = '0;
    irq_level_vec[`CEPV_IDX_IRQ3] = irq_s2_r[3];
    irq_level_vec[`CEPV_IDX_IRQ2] = irq_s2_r[2];
    irq_level_vec[`CEPV_IDX_IRQ1] = irq_s2_r[1];
    irq_level_vec[`CEPV_IDX_IRQ0] = irq_s2_r[0];
  end

  // Pending state, winner selection
  cepv_evt_vec_t pend_r, pend_nxt, cand, clr_vec;
  logic sel_found;
  cepv_idx_t sel_idx, sel_prio;
  logic take;

  assign cand = pend_r | irq_level_vec;

  cepv_prio_enc u_prio_enc (
    .req(cand),
    .found(sel_found),
    .idx(sel_idx)
  );

  assign sel_prio = sel_idx + `CEPV_PRIO_STEP;

  // Take only a strictly higher class than the one in service
  assign take = sel_found && (sel_prio < cur_prio_r) && evt_ready && !evt_done && !evt_take_r;

  // Clear the taken bit; a new pulse in the same cycle wins
  always_comb begin
    clr_vec = '0;
    if (take) begin
      clr_vec[sel_idx] = 1'b1;
    end
    pend_nxt = (pend_r & ~clr_vec) | evt_set;
  end

  // Reset event stays pending from reset until taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_r <= cepv_evt_vec_t'(1'b1);
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Nesting stack of interrupted priority classes
  logic [`CEPV_IDX_W-1:0] stack_mem [`CEPV_STACK_DEPTH];
  logic [`CEPV_SP_W-1:0] sp_r, sp_nxt;
  cepv_idx_t cur_prio_nxt;
  logic push;

  always_comb begin
    push = 1'b0;
    sp_nxt = sp_r;
    cur_prio_nxt = cur_prio_r;
    if (evt_done) begin
      if (sp_r != `CEPV_SP_EMPTY) begin
        sp_nxt = sp_r - `CEPV_SP_STEP;
        cur_prio_nxt = stack_mem[sp_nxt[`CEPV_SP_W-2:0]];
      end else begin
        cur_prio_nxt = `CEPV_PRIO_IDLE;
      end
    end else if (take) begin
      if (sel_idx == `CEPV_IDX_RESET) begin
        // Reset code runs as normal execution
        sp_nxt = `CEPV_SP_EMPTY;
        cur_prio_nxt = `CEPV_PRIO_IDLE;
      end else begin
        push = 1'b1;
        sp_nxt = sp_r + `CEPV_SP_STEP;
        cur_prio_nxt = sel_prio;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sp_r <= `CEPV_SP_EMPTY;
      cur_prio_r <= `CEPV_PRIO_IDLE;
    end else begin
      sp_r <= sp_nxt;
      cur_prio_r <= cur_prio_nxt;
    end
    if (push) begin
      stack_mem[sp_r[`CEPV_SP_W-2:0]] <= cur_prio_r;
    end
  end

  // Handler and return address of the winner
  cepv_addr_t hnd_nxt, ret_nxt;
  logic ret_valid_nxt;
  cepv_idx_t prio_nxt;
  logic [`CEPV_NUM_IRQ-1:0] ack_nxt;

  always_comb begin
    case (evt_vec_kind(sel_idx))
      CEPV_VEC_FIXED: hnd_nxt = `CEPV_RESET_ADDR;
      CEPV_VEC_DEBUG: hnd_nxt = dbg_handler_addr;
      CEPV_VEC_AUTO: hnd_nxt = form_target(event_vector_base, {`CEPV_AUTOVEC_PAD, irq_autovector});
      default: hnd_nxt = form_target(event_vector_base, evt_offset(sel_idx));
    endcase
    ret_valid_nxt = 1'b1;
    case (evt_ret_kind(sel_idx))
      CEPV_RET_OFFENDING: ret_nxt = pc_offending;
      CEPV_RET_FIRST_NC: ret_nxt = pc_first_nc;
      CEPV_RET_SVC: ret_nxt = pc_offending + `CEPV_SVC_RET_INC;
      default: begin
        ret_nxt = `CEPV_ZERO_ADDR;
        ret_valid_nxt = 1'b0;
      end
    endcase
    ack_nxt = (take && evt_vec_kind(sel_idx) == CEPV_VEC_AUTO) ? 4'h8 >> (sel_idx - `CEPV_IDX_IRQ3) : '0;
    prio_nxt = sel_prio;
    if (!take) begin
      hnd_nxt = evt_handler_addr_r;
      ret_nxt = evt_return_addr_r;
      ret_valid_nxt = evt_return_valid_r;
      prio_nxt = evt_prio_r;
    end
  end

  // Registered event outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_take_r <= 1'b0;
      evt_handler_addr_r <= `CEPV_ZERO_ADDR;
      evt_return_addr_r <= `CEPV_ZERO_ADDR;
      evt_return_valid_r <= 1'b0;
      evt_prio_r <= `CEPV_PRIO_IDLE;
      irq_ack_r <= '0;
    end else begin
      evt_take_r <= take;
      irq_ack_r <= ack_nxt;
      evt_handler_addr_r <= hnd_nxt;
      evt_return_addr_r <= ret_nxt;
      evt_return_valid_r <= ret_valid_nxt;
      evt_prio_r <= prio_nxt;
    end
  end

endmodule

// ==== test/cepv_checker.sv ====
// Checker of event take timing and handler vectoring
`timescale 1ns/100ps
`include "cepv_params.svh"

module cepv_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs watched
  input wire logic [`CEPV_AUTOVEC_W-1:0] irq_autovector,
  input wire cepv_pkg::cepv_addr_t dbg_handler_addr,
  input wire cepv_pkg::cepv_addr_t event_vector_base,
  input wire cepv_pkg::cepv_addr_t pc_offending,
  input wire cepv_pkg::cepv_addr_t pc_first_nc,
  input wire logic evt_done,
  // Outputs watched
  input wire logic [`CEPV_NUM_IRQ-1:0] irq_ack_r,
  input wire logic evt_take_r,
  input wire cepv_pkg::cepv_addr_t evt_handler_addr_r,
  input wire cepv_pkg::cepv_addr_t evt_return_addr_r,
  input wire logic evt_return_valid_r,
  input wire cepv_pkg::cepv_idx_t evt_prio_r,
  input wire cepv_pkg::cepv_idx_t cur_prio_r
);
  import cepv_pkg::*;
  // One clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Take timing
  a_take_single: assert property (evt_take_r |=> !evt_take_r)
    else $error("two takes in a row");
  a_done_blocks: assert property (evt_done |=> !evt_take_r)
    else $error("take decided in a done cycle");
  a_strict_preempt: assert property (evt_take_r |-> evt_prio_r < $past(cur_prio_r))
    else $error("take not of a higher class");
  a_cur_tracks: assert property (evt_take_r && evt_prio_r != 5'h01 |-> cur_prio_r == evt_prio_r)
    else $error("class in service not updated");
  // Interrupt levels
  a_ack_one_hot: assert property (|irq_ack_r |-> evt_take_r && $onehot(irq_ack_r))
    else $error("acknowledge without single take");
  a_irq_prio_map: assert property (|irq_ack_r |-> evt_prio_r == (irq_ack_r[3] ? 5'h08 :
    irq_ack_r[2] ? 5'h09 : irq_ack_r[1] ? 5'h0a : 5'h0b))
    else $error("interrupt level priority wrong");
  a_autovec_addr: assert property (|irq_ack_r |->
    evt_handler_addr_r == ($past(event_vector_base) | {18'h0, $past(irq_autovector)}))
    else $error("autovector address wrong");
  // Special vectors
  a_unused_slot: assert property (evt_take_r |-> evt_prio_r != 5'h13 && evt_prio_r != 5'h1c)
    else $error("unused slot raised");
  a_reset_vector: assert property (evt_take_r && evt_prio_r == 5'h01 |->
    evt_handler_addr_r == 32'h8000_0000 && !evt_return_valid_r)
    else $error("reset vector wrong");
  a_dbg_handler: assert property (evt_take_r && evt_prio_r == 5'h02 |->
    evt_handler_addr_r == $past(dbg_handler_addr))
    else $error("debug handler address wrong");
  a_nmi_return: assert property (evt_take_r && evt_prio_r == 5'h07 |->
    evt_return_valid_r && evt_return_addr_r == $past(pc_first_nc))
    else $error("nmi return address wrong");
  a_svc_return: assert property (evt_take_r && evt_prio_r == 5'h15 |->
    evt_return_addr_r == $past(pc_offending) + 32'h2 &&
    evt_handler_addr_r == ($past(event_vector_base) | 32'h100))
    else $error("supervisor call vector wrong");
endmodule

// ==== test/cepv_irq_model.sv ====
// Interrupt controller model: request levels and autovector
`timescale 1ns/100ps
`include "cepv_params.svh"

module cepv_irq_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the bench
  input wire logic [3:0] raise,
  // Toward the block
  input wire logic [3:0] irq_ack_r,
  output logic [3:0] irq_pin,
  output logic [`CEPV_AUTOVEC_W-1:0] irq_autovector
);
  // Level held until acknowledged, then dropped
  always @(posedge clk_sys) begin
    if (rst)
      irq_pin <= 4'h0;
    else
      irq_pin <= (irq_pin | raise) & ~irq_ack_r;
  end
  // Offset of the highest pending level
  always_comb begin
    irq_autovector = 14'h2a5;
    for (int l = 0; l < 4; l++) begin
      if (irq_pin[l])
        irq_autovector = {l[1:0], 12'h1a6};
    end
  end
endmodule

// ==== test/cepv_top_bench.sv ====
// Self-checking bench of event priority and vectoring
`timescale 1ns/100ps
`include "cepv_params.svh"
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
  end \
end

module cepv_top_bench;
  import cepv_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, evt_ready = 1'b1, evt_done = 1'b0;
  logic [27:0] ev = 28'h0;
  logic [3:0] raise = 4'h0, irq_pin, irq_ack_r;
  logic [13:0] irq_autovector;
  cepv_addr_t dbg_addr = 32'h0, base = 32'h0, pc_off = 32'h0, pc_nc = 32'h0;
  cepv_addr_t evt_handler_addr_r, evt_return_addr_r;
  logic evt_take_r, evt_return_valid_r;
  cepv_idx_t evt_prio_r, cur_prio_r;
  int failures = 0, check_count = 0, cyc = 0, a, b;
  localparam logic [8:0] OFFS [28] = '{9'h0, 9'h0, 9'h0, 9'h4, 9'h8, 9'hc, 9'h10, 9'h0, 9'h0, 9'h0, 9'h0,
    9'h14, 9'h50, 9'h18, 9'h1c, 9'h20, 9'h24, 9'h28, 9'h2c, 9'h30, 9'h100, 9'h34, 9'h38, 9'h60, 9'h70,
    9'h3c, 9'h40, 9'h44};
  localparam logic [27:0] OFF_PC = 28'h66ba804, NO_RET = 28'h1801009;
  localparam int EVS [21] = '{1, 2, 3, 4, 5, 6, 11, 12, 13, 14, 15, 16, 17, 19, 20, 21, 22, 23, 24, 25, 26};

  // Block under test and interrupt controller model
  cepv_top u_dut (.clk_sys(clk_sys), .rst(rst), .nmi_pin(ev[6]), .irq_pin(irq_pin),
    .irq_autovector(irq_autovector), .irq_ack_r(irq_ack_r), .dbg_stop_req(ev[1]), .dbg_breakpoint(ev[14]),
    .dbg_handler_addr(dbg_addr), .prot_multi_hit(ev[3]), .instr_protection_lookup_miss(ev[12]),
    .instr_protection_lookup_viol(ev[13]), .data_protection_lookup_miss_rd(ev[23]),
    .data_protection_lookup_miss_wr(ev[24]), .data_protection_lookup_viol_rd(ev[25]),
    .data_protection_lookup_viol_wr(ev[26]), .bus_err_data(ev[4]), .bus_err_instr(ev[5]),
    .unrecov_fault(ev[2]), .instr_addr_fault(ev[11]), .illegal_opcode(ev[15]), .unimpl_instr(ev[16]),
    .priv_violation(ev[17]), .cop_absent(ev[19]), .supervisor_call(ev[20]), .data_addr_fault_rd(ev[21]),
    .data_addr_fault_wr(ev[22]), .event_vector_base(base), .pc_offending(pc_off), .pc_first_nc(pc_nc),
    .evt_ready(evt_ready), .evt_done(evt_done), .evt_take_r(evt_take_r), .evt_handler_addr_r(evt_handler_addr_r),
    .evt_return_addr_r(evt_return_addr_r), .evt_return_valid_r(evt_return_valid_r), .evt_prio_r(evt_prio_r),
    .cur_prio_r(cur_prio_r));
  cepv_irq_model u_irq (.clk_sys(clk_sys), .rst(rst), .raise(raise), .irq_ack_r(irq_ack_r),
    .irq_pin(irq_pin), .irq_autovector(irq_autovector));

  // Clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // Expected handler and return address of one source
  function automatic cepv_addr_t exp_hdl(int i);
    return (i == 1) ? dbg_addr : (base | {23'h0, OFFS[i]});
  endfunction
  function automatic cepv_addr_t exp_ret(int i);
    if (NO_RET[i])
      return 32'h0;
    if (i == 20)
      return pc_off + 32'h2;
    return OFF_PC[i] ? pc_off : pc_nc;
  endfunction

  // Step past the edge
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic fire(input logic [27:0] m);
    ev = m;
    tick();
    ev = 28'h0;
  endtask
  task automatic rand_ctx();
    base = $urandom;
    pc_off = $urandom;
    pc_nc = $urandom;
    dbg_addr = $urandom;
  endtask
  // Wait for a take and compare everything it carries
  task automatic expect_take(input int p, input cepv_addr_t h, input cepv_addr_t r, input logic v,
    input logic [3:0] k);
    int n;
    n = 0;
    while (evt_take_r !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    `CHK(evt_take_r, 1'b1)
    `CHK(evt_prio_r, p[4:0])
    `CHK(evt_handler_addr_r, h)
    `CHK(evt_return_addr_r, r)
    `CHK(evt_return_valid_r, v)
    `CHK(irq_ack_r, k)
    `CHK(cur_prio_r, (p == 1) ? 5'h1f : p[4:0])
    tick();
  endtask
  task automatic expect_ev(input int i);
    expect_take(i + 1, exp_hdl(i), exp_ret(i), !NO_RET[i], 4'h0);
  endtask
  // Handler returns, class pops
  task automatic finish_evt(input cepv_idx_t c);
    repeat (4) tick();
    evt_done = 1'b1;
    tick();
    evt_done = 1'b0;
    `CHK(cur_prio_r, c)
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hd3c788eb));
    repeat (8) tick();
    rst = 1'b0;
    expect_take(1, 32'h8000_0000, 32'h0, 1'b0, 4'h0);
    foreach (EVS[k]) begin
      rand_ctx();
      fire(28'h1 << EVS[k]);
      expect_ev(EVS[k]);
      finish_evt(5'h1f);
    end
    // Two sources at once
    repeat (8) begin
      do begin
        a = EVS[$urandom_range(20)];
        b = EVS[$urandom_range(20)];
      end while (a == b || a == 6 || b == 6);
      rand_ctx();
      fire((28'h1 << a) | (28'h1 << b));
      expect_ev(a < b ? a : b);
      repeat (5) begin
        tick();
        `CHK(evt_take_r, 1'b0)
      end
      finish_evt(5'h1f);
      expect_ev(a < b ? b : a);
      finish_evt(5'h1f);
    end
    // Nested: higher class preempts
    rand_ctx();
    fire(28'h1 << 15);
    expect_ev(15);
    fire(28'h1 << 6);
    expect_ev(6);
    finish_evt(5'h10);
    finish_evt(5'h1f);
    // Pipeline not ready holds the event
    evt_ready = 1'b0;
    fire(28'h1 << 16);
    repeat (5) begin
      tick();
      `CHK(evt_take_r, 1'b0)
    end
    evt_ready = 1'b1;
    expect_ev(16);
    finish_evt(5'h1f);
    // All four levels, highest first
    rand_ctx();
    raise = 4'hf;
    tick();
    raise = 4'h0;
    for (int l = 3; l >= 0; l--) begin
      expect_take(11 - l, base | {18'h0, l[1:0], 12'h1a6}, pc_nc, 1'b1, 4'h1 << l);
      finish_evt(5'h1f);
    end
    give_verdict();
  end

  // Verdict and end of run
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
endmodule

bind cepv_top cepv_checker u_chk (.clk_sys(clk_sys), .rst(rst), .irq_autovector(irq_autovector),
  .dbg_handler_addr(dbg_handler_addr), .event_vector_base(event_vector_base), .pc_offending(pc_offending),
  .pc_first_nc(pc_first_nc), .evt_done(evt_done), .irq_ack_r(irq_ack_r), .evt_take_r(evt_take_r),
  .evt_handler_addr_r(evt_handler_addr_r), .evt_return_addr_r(evt_return_addr_r),
  .evt_return_valid_r(evt_return_valid_r), .evt_prio_r(evt_prio_r), .cur_prio_r(cur_prio_r));
